// [led_route_pkg.sv]
// Shared constants and carriers for the LED routing and trip indication block.
// Assumes a single 125 MHz clock domain and a synchronous reset.
package led_route_pkg;
   localparam int NUM_LEDS = 8;
   localparam int NUM_SIGS = 22;
   localparam int NUM_RETAIN = 6;
   localparam int HOLD_W = 10;
   // Switch bit positions (bit n of the group is index n-1)
   localparam int SW_THERM_ALARM = 0;
   localparam int SW_THERM_TRIP = 1;
   localparam int SW_RESTART_INH = 2;
   localparam int SW_MOTOR_START = 3;
   localparam int SW_TRIP_FIRST = 4;
   localparam int SW_TRIP_LAST = 9;
   localparam int SW_EMERG_START = 10;
   localparam int SW_DIGIN_FIRST = 11;
   localparam int SW_DIGIN_LAST = 15;
   localparam int SW_TEMP_FIRST = 16;
   localparam int SW_TEMP_LAST = 19;
   localparam int SW_BREAKER_FAIL = 20;
   localparam int SW_RECORDER = 21;
   // Reset values
   localparam logic [21:0] GROUP1_RESET = 22'h000004;
   localparam logic [21:0] GROUP2_RESET = 22'h000008;
   localparam logic [21:0] GROUPN_RESET = 22'h000000;
   localparam logic [5:0] RETAIN_RESET = 6'h3F;
   localparam logic [9:0] HOLD_RESET = 10'h03C;
   localparam logic [9:0] HOLD_MAX = 10'h3E6;
   localparam logic [9:0] HOLD_MANUAL = 10'h3E7;
   // Minute tick
   localparam int CLK_PERIOD_NS = 8;
   localparam longint MINUTE_NS = 64'd60_000_000_000;
   // A minute of 8 ns cycles needs 33 bits; an int would wrap
   localparam longint MINUTE_CYCLES = MINUTE_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 33;
   // Indication sources, one bit per routing switch
   typedef struct packed {
      logic recorder;
      logic breaker_failure_protect;
      logic [3:0] temperature_stage;
      logic [4:0] digital_input;
      logic emergency_start;
      logic [5:0] stage_trip;
      logic motor_startup;
      logic restart_inhibit;
      logic thermal_trip;
      logic thermal_alarm;
   } indication_s;
   // Retention enables as seen by storage and clock logic
   typedef struct packed {
      logic rtc_run;
      logic records;
      logic events;
      logic recorder;
      logic start_count;
      logic indications;
   } retain_s;
endpackage

// [led_route_trip_ind.sv]
// LED routing groups, trip display hold timer and retention switch decode.
// Assumes settings arrive as write strobes from the panel or serial front end.
`timescale 1ns/100ps
module led_route_trip_ind
#(
   parameter longint MINUTE_TICKS = led_route_pkg::MINUTE_CYCLES,
   parameter int TRIP_W = 8
)
(
   input wire logic CLK,
   input wire logic RESET,
   input led_route_pkg::indication_s INDICATION,
   input wire logic [2:0] GROUP_SEL,
   input wire logic GROUP_WR,
   input wire logic [21:0] GROUP_WDATA,
   input wire logic HOLD_WR,
   input wire logic [9:0] HOLD_WDATA,
   input wire logic RETAIN_WR,
   input wire logic [5:0] RETAIN_WDATA,
   input wire logic [TRIP_W-1:0] TRIP_CODE,
   input wire logic TRIP_VALID,
   input wire logic TRIP_CLEAR,
   input wire logic BATTERY_OK,
   output logic [7:0] LED,
   output logic [21:0] GROUP_RDATA,
   output logic [9:0] HOLD_RDATA,
   output logic [5:0] RETAIN_RDATA,
   output logic [TRIP_W-1:0] TRIP_DISPLAY,
   output logic TRIP_SHOWN,
   output led_route_pkg::retain_s RETAIN_ACTIVE,
   output logic BATT_SUPERVISE
);
   import led_route_pkg::*;

   logic [21:0] led_route_groups [NUM_LEDS];
   logic [9:0] trip_display_hold_time_r;
   logic [5:0] retention_r;
   logic [7:0] led_nxt;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [9:0] minutes_r;
   logic hold_over;
   logic tick;
   logic [21:0] ind_vec;
   logic trip_take;
   logic [9:0] hold_lim;

   // Group value is the plain weighted sum of its switches
   function automatic logic route_hit(input logic [21:0] sel, input logic [21:0] sig);
      route_hit = |(sel & sig);
   endfunction

   // Packed struct order puts bit 1 of the group at index 0
   assign ind_vec = INDICATION;

   // LED decode, one OR per routing group
   always_comb
   begin
      for (int i = 0; i < NUM_LEDS; i++)
      begin
         led_nxt[i] = route_hit(led_route_groups[i], ind_vec);
      end
   end

   // Routing group storage; the write value is the weighted sum
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         for (int i = 0; i < NUM_LEDS; i++)
         begin
            led_route_groups[i] <= (i == 0) ? GROUP1_RESET :
                                   (i == 1) ? GROUP2_RESET : GROUPN_RESET;
         end
      end
      else if (GROUP_WR)
      begin
         led_route_groups[GROUP_SEL] <= GROUP_WDATA;
      end
   end

   // LED and readback outputs
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         LED <= 8'h00;
         GROUP_RDATA <= GROUP1_RESET;
      end
      else
      begin
         LED <= led_nxt;
         GROUP_RDATA <= led_route_groups[GROUP_SEL];
      end
   end

   // Hold time setting; out-of-range values are ignored
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         trip_display_hold_time_r <= HOLD_RESET;
      end
      else if (HOLD_WR && HOLD_WDATA <= HOLD_MANUAL)
      begin
         trip_display_hold_time_r <= HOLD_WDATA;
      end
   end

   // Minute prescaler restarts with each newly shown trip
   assign tick = (tick_cnt_r == TICK_W'(MINUTE_TICKS - 1));
   assign hold_lim = trip_display_hold_time_r;
   assign hold_over = (hold_lim != HOLD_MANUAL) && (minutes_r >= hold_lim);
   assign trip_take = TRIP_VALID && (!TRIP_SHOWN || hold_over);

   // Display latch; it never feeds back into the protection inputs
   always_ff @(posedge CLK)
   begin
      if (RESET || TRIP_CLEAR)
      begin
         TRIP_SHOWN <= 1'b0;
         TRIP_DISPLAY <= '0;
         tick_cnt_r <= '0;
         minutes_r <= 10'h000;
      end
      else if (trip_take)
      begin
         TRIP_SHOWN <= 1'b1;
         TRIP_DISPLAY <= TRIP_CODE;
         tick_cnt_r <= '0;
         minutes_r <= 10'h000;
      end
      else if (TRIP_SHOWN)
      begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
         if (tick && minutes_r != 10'h3FF)
         begin
            minutes_r <= minutes_r + 10'h001;
         end
      end
   end

   // Retention switches; clearing all of them stops battery supervision
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         retention_r <= RETAIN_RESET;
         RETAIN_ACTIVE <= '0;
         BATT_SUPERVISE <= 1'b1;
         HOLD_RDATA <= HOLD_RESET;
         RETAIN_RDATA <= RETAIN_RESET;
      end
      else
      begin
         if (RETAIN_WR)
         begin
            retention_r <= RETAIN_WDATA;
         end
         RETAIN_ACTIVE <= retention_r & {NUM_RETAIN{BATTERY_OK}};
         BATT_SUPERVISE <= |retention_r;
         HOLD_RDATA <= trip_display_hold_time_r;
         RETAIN_RDATA <= retention_r;
      end
   end

   a_led_follows_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED == $past(led_nxt)) else $error("LED not following route");
   a_manual_hold_blocks: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && hold_lim == HOLD_MANUAL && !TRIP_CLEAR |=> TRIP_SHOWN &&
      $stable(TRIP_DISPLAY)) else $error("Manual hold replaced");
   a_first_trip_kept: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && !hold_over && !TRIP_CLEAR |=> $stable(TRIP_DISPLAY))
      else $error("Trip replaced early");
   a_retain_battery: assert property (@(posedge CLK) disable iff (RESET)
      !BATTERY_OK |=> RETAIN_ACTIVE == '0) else $error("Retention without battery");
   a_supervise_off: assert property (@(posedge CLK) disable iff (RESET)
      retention_r == 6'h00 |=> !BATT_SUPERVISE) else $error("Supervision not off");
   a_hold_range: assert property (@(posedge CLK) disable iff (RESET)
      trip_display_hold_time_r <= HOLD_MANUAL) else $error("Hold out of range");
   a_minute_count: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && tick && !trip_take && !TRIP_CLEAR && minutes_r != 10'h3FF
      |=> minutes_r == $past(minutes_r) + 10'h001) else $error("Minute miscount");
   a_first_taken: assert property (@(posedge CLK) disable iff (RESET)
      !TRIP_SHOWN && TRIP_VALID && !TRIP_CLEAR |=> TRIP_SHOWN &&
      TRIP_DISPLAY == $past(TRIP_CODE)) else $error("First trip missed");

   // Each LED is the OR of its own group's selected inputs, one edge late
   a_led1_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[0] == $past(|(led_route_groups[0] & ind_vec)))
      else $error("LED1 route wrong");
   a_led2_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[1] == $past(|(led_route_groups[1] & ind_vec)))
      else $error("LED2 route wrong");
   a_led3_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[2] == $past(|(led_route_groups[2] & ind_vec)))
      else $error("LED3 route wrong");
   a_led4_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[3] == $past(|(led_route_groups[3] & ind_vec)))
      else $error("LED4 route wrong");
   a_led5_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[4] == $past(|(led_route_groups[4] & ind_vec)))
      else $error("LED5 route wrong");
   a_led6_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[5] == $past(|(led_route_groups[5] & ind_vec)))
      else $error("LED6 route wrong");
   a_led7_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[6] == $past(|(led_route_groups[6] & ind_vec)))
      else $error("LED7 route wrong");
   a_led8_route: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> LED[7] == $past(|(led_route_groups[7] & ind_vec)))
      else $error("LED8 route wrong");

   // Switch positions; a reordered carrier would silently swap LEDs
   a_therm_alarm_bit: assert property (@(posedge CLK)
      ind_vec[SW_THERM_ALARM] == INDICATION.thermal_alarm) else $error("Switch 1 misplaced");
   a_therm_trip_bit: assert property (@(posedge CLK)
      ind_vec[SW_THERM_TRIP] == INDICATION.thermal_trip) else $error("Switch 2 misplaced");
   a_restart_bit: assert property (@(posedge CLK)
      ind_vec[SW_RESTART_INH] == INDICATION.restart_inhibit) else $error("Switch 3 misplaced");
   a_motor_bit: assert property (@(posedge CLK)
      ind_vec[SW_MOTOR_START] == INDICATION.motor_startup) else $error("Switch 4 misplaced");
   a_stage_trip_bits: assert property (@(posedge CLK)
      ind_vec[SW_TRIP_LAST:SW_TRIP_FIRST] == INDICATION.stage_trip) else $error("Trips misplaced");
   a_emerg_bit: assert property (@(posedge CLK)
      ind_vec[SW_EMERG_START] == INDICATION.emergency_start) else $error("Switch 11 misplaced");
   a_digin_bits: assert property (@(posedge CLK)
      ind_vec[SW_DIGIN_LAST:SW_DIGIN_FIRST] == INDICATION.digital_input) else $error("Inputs moved");
   a_breaker_bit: assert property (@(posedge CLK)
      ind_vec[SW_BREAKER_FAIL] == INDICATION.breaker_failure_protect) else $error("Switch 21 moved");
   a_recorder_bit: assert property (@(posedge CLK)
      ind_vec[SW_RECORDER] == INDICATION.recorder) else $error("Switch 22 misplaced");
   a_temp_bits: assert property (@(posedge CLK)
      ind_vec[SW_TEMP_LAST:SW_TEMP_FIRST] == INDICATION.temperature_stage) else $error("Temps moved");

   // Defaults after reset
   a_group1_default: assert property (@(posedge CLK)
      RESET |=> led_route_groups[0] == GROUP1_RESET) else $error("Group 1 default wrong");
   a_group2_default: assert property (@(posedge CLK)
      RESET |=> led_route_groups[1] == GROUP2_RESET) else $error("Group 2 default wrong");
   a_groups_cleared: assert property (@(posedge CLK)
      RESET |=> (led_route_groups[2] | led_route_groups[3] | led_route_groups[4] |
      led_route_groups[5] | led_route_groups[6] | led_route_groups[7]) == GROUPN_RESET)
      else $error("Groups 3-8 default wrong");
   a_hold_default: assert property (@(posedge CLK)
      RESET |=> HOLD_RDATA == HOLD_RESET) else $error("Hold default wrong");
   a_retain_default: assert property (@(posedge CLK)
      RESET |=> RETAIN_RDATA == RETAIN_RESET && BATT_SUPERVISE) else $error("Retain default");
   a_led_reset: assert property (@(posedge CLK)
      RESET |=> LED == 8'h00) else $error("LED lit in reset");

   // Settings writes and readback
   a_group_write: assert property (@(posedge CLK) disable iff (RESET)
      GROUP_WR |=> led_route_groups[$past(GROUP_SEL)] == $past(GROUP_WDATA))
      else $error("Group write lost");
   a_group_readback: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> GROUP_RDATA == $past(led_route_groups[GROUP_SEL]))
      else $error("Group readback wrong");
   a_hold_write: assert property (@(posedge CLK) disable iff (RESET)
      HOLD_WR && HOLD_WDATA <= HOLD_MANUAL |=> trip_display_hold_time_r == $past(HOLD_WDATA))
      else $error("Hold write lost");
   a_hold_ignore: assert property (@(posedge CLK) disable iff (RESET)
      HOLD_WR && HOLD_WDATA > HOLD_MANUAL |=> $stable(trip_display_hold_time_r))
      else $error("Bad hold accepted");
   a_hold_readback: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> HOLD_RDATA == $past(trip_display_hold_time_r))
      else $error("Hold readback wrong");
   a_retain_write: assert property (@(posedge CLK) disable iff (RESET)
      RETAIN_WR |=> retention_r == $past(RETAIN_WDATA))
      else $error("Retention write lost");
   a_retain_readback: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_RDATA == $past(retention_r))
      else $error("Retention readback wrong");

   // Retention outputs follow their switch only with a good battery
   a_retain_gate: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE == ($past(retention_r) & {NUM_RETAIN{$past(BATTERY_OK)}}))
      else $error("Retention gate wrong");
   a_indication_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.indications == $past(retention_r[0] && BATTERY_OK))
      else $error("Indication retention wrong");
   a_start_count_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.start_count == $past(retention_r[1] && BATTERY_OK))
      else $error("Start count retention wrong");
   a_recorder_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.recorder == $past(retention_r[2] && BATTERY_OK))
      else $error("Recorder retention wrong");
   a_events_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.events == $past(retention_r[3] && BATTERY_OK))
      else $error("Event retention wrong");
   a_records_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.records == $past(retention_r[4] && BATTERY_OK))
      else $error("Record retention wrong");
   a_rtc_keep: assert property (@(posedge CLK) disable iff (RESET)
      1'b1 |=> RETAIN_ACTIVE.rtc_run == $past(retention_r[5] && BATTERY_OK))
      else $error("Clock retention wrong");
   a_supervise_on: assert property (@(posedge CLK) disable iff (RESET)
      retention_r != 6'h00 |=> BATT_SUPERVISE)
      else $error("Supervision dropped");

   // Display latch and minute count
   a_clear_wins: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_CLEAR |=> !TRIP_SHOWN && TRIP_DISPLAY == '0)
      else $error("Clear ignored");
   a_hold_expiry: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && hold_over && TRIP_VALID && !TRIP_CLEAR |=> TRIP_DISPLAY == $past(TRIP_CODE))
      else $error("Newer trip not taken");
   a_tick_restart: assert property (@(posedge CLK) disable iff (RESET)
      trip_take && !TRIP_CLEAR |=> minutes_r == 10'h000 && tick_cnt_r == '0)
      else $error("Hold timer not restarted");
   a_display_idle: assert property (@(posedge CLK) disable iff (RESET)
      !TRIP_SHOWN |-> TRIP_DISPLAY == '0)
      else $error("Stale display code");
   a_trip_held: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && !TRIP_CLEAR |=> TRIP_SHOWN)
      else $error("Display dropped");
   a_minutes_idle: assert property (@(posedge CLK) disable iff (RESET)
      TRIP_SHOWN && !tick && !trip_take && !TRIP_CLEAR |=> $stable(minutes_r))
      else $error("Minutes moved off tick");
endmodule

// [led_route_stage_model.sv]
// Stage logic stand-in: raises one indication source, chosen by switch index.
// Assumes requests change just after a rising clk edge.
`timescale 1ns/100ps
module led_route_stage_model
(
   input wire logic clk,
   input wire logic fire,
   input wire logic [4:0] num,
   output led_route_pkg::indication_s ind
);
   import led_route_pkg::*;
   initial ind = '0;
   // One source at a time keeps every route distinguishable
   always @(posedge clk)
   begin
      ind <= fire ? indication_s'(22'h1 << num) : '0;
   end
endmodule

// [led_route_trip_ind_tb.sv]
// Self-checking bench for the LED routing and trip display block.
// Assumes a short minute prescale so hold times finish in a few cycles.
`timescale 1ns/100ps
module led_route_trip_ind_tb;
   import led_route_pkg::*;
   logic CLK = 0, RESET = 1, fire = 0, gwr = 0, hwr = 0, rwr = 0, tv = 0, tclr = 0, bok = 1;
   logic [4:0] num = 0;
   logic [2:0] sel = 0;
   logic [21:0] gdat = 0, grd;
   logic [9:0] hrd;
   logic [5:0] rrd;
   logic [7:0] tcode = 0, led, tdisp;
   logic tshown, bsup;
   indication_s ind;
   retain_s ract;
   int n_errors = 0, n_checks = 0;
   led_route_stage_model u_led_route_stage_model (.clk(CLK), .fire(fire), .num(num), .ind(ind));
   led_route_trip_ind #(.MINUTE_TICKS(10), .TRIP_W(8)) u_led_route_trip_ind (.CLK(CLK),
      .RESET(RESET), .INDICATION(ind), .GROUP_SEL(sel), .GROUP_WR(gwr), .GROUP_WDATA(gdat),
      .HOLD_WR(hwr), .HOLD_WDATA(gdat[9:0]), .RETAIN_WR(rwr), .RETAIN_WDATA(gdat[5:0]),
      .TRIP_CODE(tcode), .TRIP_VALID(tv), .TRIP_CLEAR(tclr), .BATTERY_OK(bok), .LED(led),
      .GROUP_RDATA(grd), .HOLD_RDATA(hrd), .RETAIN_RDATA(rrd), .TRIP_DISPLAY(tdisp),
      .TRIP_SHOWN(tshown), .RETAIN_ACTIVE(ract), .BATT_SUPERVISE(bsup));
   initial forever #4 CLK = ~CLK;
   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // One strobe per write; which: 0 group, 1 hold, 2 retention
   task automatic wr(input int which, input logic [2:0] s, input logic [21:0] d);
      @(posedge CLK);
      sel <= s;
      gdat <= d;
      gwr <= (which == 0);
      hwr <= (which == 1);
      rwr <= (which == 2);
      @(posedge CLK);
      {gwr, hwr, rwr} <= 3'h0;
      step(2);
   endtask
   // Readback is registered, so let two edges pass after the select
   task automatic rd_group(input logic [2:0] s, input logic [21:0] exp);
      @(posedge CLK);
      sel <= s;
      step(2);
      chk("group", exp, grd);
   endtask
   // Offer a trip for one edge, then look at the display
   task automatic trip(input logic [7:0] c, input logic [7:0] exp);
      @(posedge CLK);
      tv <= 1'b1;
      tcode <= c;
      @(posedge CLK);
      tv <= 1'b0;
      step(1);
      chk("trip", {14'h0, exp}, {14'h0, tdisp});
   endtask
   task automatic lit(input logic [4:0] k, input logic [7:0] exp);
      @(posedge CLK);
      fire <= 1'b1;
      num <= k;
      step(3);
      chk("led", {14'h0, exp}, {14'h0, led});
   endtask
   initial
   begin
      step(3);
      RESET <= 1'b0;
      step(1);
      chk("hold", 22'd60, {12'h0, hrd});
      chk("retain", 22'h3F, {16'h0, rrd});
      chk("supervise", 22'h1, {21'h0, bsup});
      for (int s = 0; s < 8; s++)
         rd_group(3'(s), (s == 0) ? 22'h4 : (s == 1) ? 22'h8 : 22'h0);
      // Every source routed alone through group k mod 8
      for (int k = 0; k < 22; k++)
      begin
         wr(0, 3'(k % 8), 22'h1 << k);
         lit(5'(k), 8'h1 << (k % 8));
      end
      rd_group(3'h5, 22'h200000);
      wr(0, 3'h0, 22'h3);
      lit(5'd1, 8'h01);
      lit(5'd0, 8'h01);
      wr(1, 3'h0, 22'd1000);
      chk("hold", 22'd60, {12'h0, hrd});
      wr(1, 3'h0, 22'd1);
      trip(8'hA1, 8'hA1);
      trip(8'hB2, 8'hA1);
      step(25);
      trip(8'hB2, 8'hB2);
      wr(1, 3'h0, 22'd999);
      tclr <= 1'b1;
      step(1);
      tclr <= 1'b0;
      step(1);
      chk("shown", 22'h0, {21'h0, tshown});
      trip(8'hC3, 8'hC3);
      step(25);
      trip(8'hD4, 8'hC3);
      wr(2, 3'h0, 22'h0);
      chk("supervise", 22'h0, {21'h0, bsup});
      wr(2, 3'h0, 22'h21);
      chk("active", 22'h21, {16'h0, ract});
      bok <= 1'b0;
      step(2);
      chk("active", 22'h0, {16'h0, ract});
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge CLK);
      n_errors++;
      finish_test();
   end
endmodule
